// File: i2c_master_model.sv
// Two-wire bus master model: 800 ns bits, 500 ns low and 300 ns high.
// Assumes the data line has a pull-up and is fed back on sda_in.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic clk_sys_in,
  // Link
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic start_cond();
    w(2);
    sda_low_out = 1'b0;
    w(4);
    scl_out = 1'b1;
    w(4);
    sda_low_out = 1'b1;
    w(4);
    scl_out = 1'b0;
  endtask
  task automatic stop_cond();
    w(2);
    sda_low_out = 1'b1;
    w(3);
    scl_out = 1'b1;
    w(4);
    sda_low_out = 1'b0;
    w(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_low_out = ~b;
    w(3);
    scl_out = 1'b1;
    w(3);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// File: pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes only the second stage is read by other logic.
// Reset value per bit should match each pin's idle level.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pin_sync
`default_nettype wire

// File: rtc_serial_pkg.sv
// Constants, types and field layouts shared by the serial RTC port.
// Assumes a 10 MHz system clock; link and pin signals are asynchronous.
package rtc_serial_pkg;
  localparam logic [7:0] SLAVE_BYTE = 8'hD0;
  localparam logic [7:0] ADDR_TIME_LAST = 8'h07;
  localparam logic [7:0] ADDR_ALARM_CTRL = 8'h0A;
  localparam logic [7:0] ADDR_FLAGS = 8'h0F;
  localparam logic [7:0] ADDR_TAMPER1 = 8'h14;
  localparam logic [7:0] ADDR_TAMPER2 = 8'h15;
  localparam logic [7:0] ADDR_LAST = 8'h9F;
  localparam int FLAG_CH1_BIT = 0;
  localparam int FLAG_CH2_BIT = 1;
  localparam int BACKUP_ALARM_EN_BIT = 5;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] ALARM_CTRL_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RECOVERY_MS = 200;
  localparam int RECOVERY_CYCLES = RECOVERY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_t;

  typedef struct packed {
    logic detect_enable;
    logic tamper_irq_enable;
    logic switch_type;
    logic trigger_polarity;
    logic [3:0] spare;
  } tamper_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } bus_state_t;
endpackage

// File: rtc_serial_port.sv
// Two-wire slave register port with power-fail supervision and tamper flags.
// Assumes SCL/SDA and supervisor pins are asynchronous; live time is on clk_sys_in.
`timescale 1ns/1ns
`default_nettype none
module rtc_serial_port
  import rtc_serial_pkg::*;
#(
  parameter int RECOVERY_CYCLES_P = RECOVERY_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Supply supervision
  input wire logic power_fail_in,
  input wire logic battery_mode_in,
  // Tamper pins
  input wire logic tamper_input_one_in,
  input wire logic tamper_input_two_in,
  // Clock core
  input wire logic [63:0] live_time_in,
  output logic time_write_valid_out,
  output wr_req_t time_write_out,
  // External RAM select
  input wire logic chip_enable_ext_n_in,
  output logic conditioned_chip_enable_n_out,
  output logic conditioned_chip_enable_oe_out,
  // Open-drain reset and interrupt
  output logic reset_n_out,
  output logic reset_oe_out,
  output logic irq_n_out,
  output logic irq_oe_out
);
  localparam int RW = $clog2(RECOVERY_CYCLES_P + 1);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  function automatic logic in_time(input logic [7:0] a);
    return a <= ADDR_TIME_LAST;
  endfunction

  logic [6:0] sync_q;
  logic scl_d;
  logic sda_d;
  logic [RW-1:0] recov_cnt;
  bus_state_t state;
  logic [7:0] ptr;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic byte_full;
  logic rw;
  logic master_ack;
  logic sda_drive;
  logic [7:0] user_time [8];
  logic [7:0] alarm_ctrl;
  tamper_cfg_t cfg1;
  tamper_cfg_t cfg2;
  logic flag1;
  logic flag2;
  logic push_ready;
  logic pop_valid;
  wr_req_t pop_data;

  pin_sync #(.WIDTH(7), .RESET_VALUE(7'h43)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({chip_enable_ext_n_in, tamper_input_two_in, tamper_input_one_in,
               battery_mode_in, power_fail_in, sda_in, scl_in}),
    .sync_out(sync_q)
  );

  wire scl_s = sync_q[0];
  wire sda_s = sync_q[1];
  wire pf_s = sync_q[2];
  wire batt_s = sync_q[3];
  wire tp1_s = sync_q[4];
  wire tp2_s = sync_q[5];
  wire ex_n_s = sync_q[6];

  // Bus conditions from sampled lines
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Supervisor state
  wire recovering = pf_s | (recov_cnt != '0);
  wire blocked = recovering;

  // Decode
  wire addr_match = (shreg[7:1] == SLAVE_BYTE[7:1]);
  wire ack_ok = (state == ST_ADDR) ? addr_match : (state == ST_WDATA) ? push_ready : 1'b1;
  wire [7:0] next_ptr = (ptr == ADDR_LAST) ? PTR_RESET : ptr + 8'h01;
  wire frozen = (state != ST_IDLE) && in_time(ptr);
  wire [7:0] flags_byte = 8'(({7'h00, flag1} << FLAG_CH1_BIT) | ({7'h00, flag2} << FLAG_CH2_BIT));
  wire [7:0] rd_data = in_time(ptr) ? user_time[ptr[2:0]] :
                       (ptr == ADDR_ALARM_CTRL) ? alarm_ctrl :
                       (ptr == ADDR_FLAGS) ? flags_byte :
                       (ptr == ADDR_TAMPER1) ? cfg1 :
                       (ptr == ADDR_TAMPER2) ? cfg2 : 8'h00;
  wire push_valid = (state == ST_WDATA_ACK) && scl_rise && !blocked;
  wire pop_ready = blocked | !(frozen && in_time(pop_data.addr));
  wire apply = pop_valid && pop_ready && !blocked;
  wire trig1 = (tp1_s == cfg1.trigger_polarity);
  wire trig2 = (tp2_s == cfg2.trigger_polarity);
  wire irq_act = ((flag1 & cfg1.tamper_irq_enable) | (flag2 & cfg2.tamper_irq_enable)) &
                 (~batt_s | alarm_ctrl[BACKUP_ALARM_EN_BIT]);

  bus_state_t ack_state;
  assign ack_state = !ack_ok ? ST_IGNORE :
                     (state == ST_ADDR) ? ST_ADDR_ACK :
                     (state == ST_WORD) ? ST_WORD_ACK : ST_WDATA_ACK;

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_drive;
  assign reset_n_out = 1'b0;
  assign irq_n_out = 1'b0;

  stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in({ptr, shreg}),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_data)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Recovery period after supply returns
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) recov_cnt <= '0;
    else if (pf_s) recov_cnt <= RW'(RECOVERY_CYCLES_P);
    else if (recov_cnt != '0) recov_cnt <= recov_cnt - RW'(1);
  end

  // Serial protocol engine
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      ptr <= PTR_RESET;
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      rw <= 1'b0;
      master_ack <= 1'b0;
      sda_drive <= 1'b0;
    end else if (blocked) begin
      state <= ST_IDLE;
      ptr <= PTR_RESET;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      sda_drive <= 1'b0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      byte_full <= 1'b0;
      sda_drive <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WORD, ST_WDATA: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            byte_full <= (bit_cnt == 3'h7);
          end else if (scl_fall && byte_full) begin
            byte_full <= 1'b0;
            state <= ack_state;
            sda_drive <= ack_ok;
            if (state == ST_ADDR) rw <= shreg[0];
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (rw) begin
              shreg <= rd_data;
              sda_drive <= ~rd_data[7];
              state <= ST_RDATA;
            end else begin
              sda_drive <= 1'b0;
              state <= ST_WORD;
            end
          end
        end
        ST_WORD_ACK: begin
          if (scl_rise) ptr <= shreg;
          else if (scl_fall) begin
            sda_drive <= 1'b0;
            state <= ST_WDATA;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_rise) ptr <= next_ptr;
          else if (scl_fall) begin
            sda_drive <= 1'b0;
            state <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_drive <= 1'b0;
              state <= ST_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_drive <= ~shreg[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
            if (!sda_s) ptr <= next_ptr;
          end else if (scl_fall) begin
            if (master_ack) begin
              shreg <= rd_data;
              sda_drive <= ~rd_data[7];
              bit_cnt <= 3'h0;
              state <= ST_RDATA;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_drive <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // User-visible time copy and drained writes
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 8; i++) user_time[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (apply && in_time(pop_data.addr) && pop_data.addr[2:0] == 3'(i)) user_time[i] <= pop_data.data;
        else if (!frozen) user_time[i] <= live_time_in[8*i +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_ctrl <= ALARM_CTRL_RESET;
      cfg1 <= CFG_RESET;
      cfg2 <= CFG_RESET;
      time_write_valid_out <= 1'b0;
      time_write_out <= '0;
    end else begin
      time_write_valid_out <= apply && in_time(pop_data.addr);
      if (apply) time_write_out <= pop_data;
      if (apply && pop_data.addr == ADDR_ALARM_CTRL) alarm_ctrl <= pop_data.data;
      if (apply && pop_data.addr == ADDR_TAMPER1) cfg1 <= pop_data.data;
      if (apply && pop_data.addr == ADDR_TAMPER2) cfg2 <= pop_data.data;
    end
  end

  // Tamper flags, read-only, cleared only while disabled
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flag1 <= 1'b0;
      flag2 <= 1'b0;
    end else begin
      flag1 <= cfg1.detect_enable & (flag1 | trig1);
      flag2 <= cfg2.detect_enable & (flag2 | trig2);
    end
  end

  // Supervisor outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reset_oe_out <= 1'b0;
      conditioned_chip_enable_n_out <= 1'b1;
      conditioned_chip_enable_oe_out <= 1'b0;
      irq_oe_out <= 1'b0;
    end else begin
      reset_oe_out <= recovering & ~batt_s;
      conditioned_chip_enable_n_out <= recovering | ex_n_s;
      conditioned_chip_enable_oe_out <= ~batt_s;
      irq_oe_out <= irq_act;
    end
  end

  sequence s_addr_byte;
    state == ST_ADDR && scl_fall && byte_full && addr_match && !blocked && !stop_cond;
  endsequence
  sequence s_wr_ack_clock;
    state == ST_WDATA_ACK && scl_rise && !blocked;
  endsequence
  sequence s_rd_ack_clock;
    state == ST_RACK && scl_rise && !sda_s && !blocked;
  endsequence

  chk_addr_ack_drive: assert property (s_addr_byte |=> state == ST_ADDR_ACK && sda_oe_out)
    else $error("address byte not acknowledged");
  chk_ptr_ack_only: assert property ($changed(ptr) && !$past(blocked) |->
      $past(scl_rise) && $past(state) inside {ST_WORD_ACK, ST_WDATA_ACK, ST_RACK})
    else $error("pointer moved outside acknowledge clock");
  chk_write_advance: assert property (s_wr_ack_clock |=> ptr == $past(next_ptr))
    else $error("write pointer did not advance");
  chk_read_advance: assert property (s_rd_ack_clock |=> ptr == $past(next_ptr))
    else $error("read pointer did not advance");
  chk_word_load: assert property (state == ST_WORD_ACK && scl_rise && !blocked |=> ptr == $past(shreg))
    else $error("word address not loaded");
  chk_read_from_ptr: assert property (state == ST_ADDR_ACK && rw && scl_fall && !blocked
      |=> shreg == $past(rd_data) && state == ST_RDATA)
    else $error("read did not start at pointer");
  chk_freeze_hold: assert property (frozen |=> $stable(user_time[0]))
    else $error("time copy changed while frozen");
  chk_copy_live: assert property (!frozen && !apply |=> user_time[1] == $past(live_time_in[15:8]))
    else $error("time copy not refreshed");
  chk_pf_abort: assert property (pf_s |=> state == ST_IDLE && ptr == PTR_RESET)
    else $error("power fail did not abort access");
  chk_pf_protect: assert property (blocked |=> !time_write_valid_out && $stable(cfg1) && $stable(cfg2))
    else $error("register written while blocked");
  chk_reset_assert: assert property ($rose(pf_s) && !batt_s |=> reset_oe_out)
    else $error("reset not asserted on power fail");
  chk_ce_inhibit: assert property (recovering |=> conditioned_chip_enable_n_out)
    else $error("chip enable not inhibited");
  chk_recov_hold: assert property ($fell(pf_s) |-> recovering [*8])
    else $error("recovery period cut short");
  chk_batt_float: assert property (batt_s |=> !reset_oe_out && !conditioned_chip_enable_oe_out)
    else $error("outputs driven in battery backup");
  chk_flag_set: assert property (cfg1.detect_enable && trig1 |=> flag1)
    else $error("tamper flag not set");
  chk_flag_clear: assert property (!cfg2.detect_enable |=> !flag2)
    else $error("tamper flag not cleared");
  chk_irq_raise: assert property (flag1 && cfg1.tamper_irq_enable && !batt_s |=> irq_oe_out)
    else $error("tamper interrupt missing");
  chk_irq_backup: assert property (batt_s && !alarm_ctrl[BACKUP_ALARM_EN_BIT] |=> !irq_oe_out)
    else $error("interrupt in backup without enable");
  chk_start_reset: assert property (start_cond && !blocked |=> state == ST_ADDR && bit_cnt == 3'h0)
    else $error("start did not restart address phase");
  chk_nack_release: assert property (state == ST_IGNORE |-> !sda_oe_out)
    else $error("data line held after nack");
endmodule // rtc_serial_port
`default_nettype wire

// File: stream_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;

  assign in_ready_out = (count != (AW + 1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      if (push && !pop) count <= count + (AW + 1)'(1);
      else if (pop && !push) count <= count - (AW + 1)'(1);
    end
  end
endmodule // stream_fifo
`default_nettype wire

// File: tb_rtc_serial_access_tamper_flags.sv
// Self-checking bench for rtc_serial_port driven by the two-wire master model.
// Assumes rtc_serial_pkg and i2c_master_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module tb_rtc_serial_access_tamper_flags;
  import rtc_serial_pkg::*;
  localparam int REC = 20;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic pf = 1'b0;
  logic batt = 1'b0;
  logic tp1 = 1'b0;
  logic tp2 = 1'b1;
  logic ext_n = 1'b0;
  logic [63:0] live = 64'h8877665544332211;
  logic scl, m_low, sda_out, sda_oe, tw_valid, ce_n, ce_oe, rst_oe, irq_oe, rst_lvl, irq_lvl;
  wire logic sda;
  wr_req_t tw_data, tw_first, tw_last;
  int fails = 0;
  int n_tests = 0;
  int tw_cnt = 0;
  assign sda = ~(m_low | (sda_oe & ~sda_out));
  always #50 clk_sys_in = ~clk_sys_in;
  i2c_master_model m (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  rtc_serial_port #(.RECOVERY_CYCLES_P(REC)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe), .power_fail_in(pf), .battery_mode_in(batt),
    .tamper_input_one_in(tp1), .tamper_input_two_in(tp2), .live_time_in(live), .time_write_valid_out(tw_valid),
    .time_write_out(tw_data), .chip_enable_ext_n_in(ext_n), .conditioned_chip_enable_n_out(ce_n),
    .conditioned_chip_enable_oe_out(ce_oe), .reset_n_out(rst_lvl), .reset_oe_out(rst_oe),
    .irq_n_out(irq_lvl), .irq_oe_out(irq_oe));
  always @(posedge clk_sys_in) begin
    if (tw_valid === 1'b1) begin
      if (tw_cnt == 0) tw_first = tw_data;
      tw_last = tw_data;
      tw_cnt++;
    end
  end
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic sel(input logic rd, input logic exp);
    logic ack;
    m.start_cond();
    m.put_byte(SLAVE_BYTE | {7'h00, rd}, ack);
    `CHK("slave ack", exp, ack)
  endtask
  task automatic point(input logic [7:0] a);
    logic ack;
    sel(1'b0, 1'b1);
    m.put_byte(a, ack);
    `CHK("word ack", 1'b1, ack)
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    logic ack;
    point(a);
    m.put_byte(d, ack);
    `CHK("data ack", 1'b1, ack)
    m.stop_cond();
  endtask
  task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    point(a);
    sel(1'b1, 1'b1);
    m.get_byte(1'b0, d);
    m.stop_cond();
    `CHK("read", exp, d)
  endtask
  task automatic t_regs();
    logic ack;
    logic [7:0] d0;
    logic [7:0] d1;
    point(ADDR_TAMPER1);
    m.put_byte(8'h0A, ack);
    m.put_byte(8'h05, ack);
    m.stop_cond();
    point(ADDR_TAMPER1);
    sel(1'b1, 1'b1);
    m.get_byte(1'b1, d0);
    m.get_byte(1'b0, d1);
    m.stop_cond();
    `CHK("seq rd 14h", 8'h0A, d0)
    `CHK("seq rd 15h", 8'h05, d1)
    point(ADDR_TAMPER2);
    m.stop_cond();
    sel(1'b1, 1'b1);
    m.get_byte(1'b0, d0);
    m.stop_cond();
    `CHK("current rd", 8'h05, d0)
    point(ADDR_LAST);
    sel(1'b1, 1'b1);
    m.get_byte(1'b1, d0);
    m.get_byte(1'b0, d1);
    m.stop_cond();
    `CHK("unmapped rd", 8'h00, d0)
    `CHK("wrap rd", live[7:0], d1)
    m.start_cond();
    m.put_byte(8'hD2, ack);
    m.stop_cond();
    `CHK("other slave", 1'b0, ack)
    rd1(ADDR_FLAGS, 8'h00);
  endtask
  task automatic t_tamper();
    wr1(ADDR_TAMPER1, 8'hF0);
    cyc(6);
    `CHK("no tamper", 1'b0, irq_oe)
    tp1 = 1'b1;
    cyc(6);
    `CHK("irq ch1", 1'b1, irq_oe)
    `CHK("irq pin level", 1'b0, irq_lvl)
    tp1 = 1'b0;
    wr1(ADDR_FLAGS, 8'h00);
    rd1(ADDR_FLAGS, 8'h01);
    wr1(ADDR_TAMPER1, 8'h70);
    cyc(6);
    `CHK("irq cleared", 1'b0, irq_oe)
    rd1(ADDR_FLAGS, 8'h00);
    wr1(ADDR_TAMPER2, 8'h80);
    tp2 = 1'b0;
    cyc(6);
    rd1(ADDR_FLAGS, 8'h02);
    `CHK("irq masked", 1'b0, irq_oe)
    wr1(ADDR_TAMPER2, 8'h00);
    tp1 = 1'b1;
    rd1(ADDR_FLAGS, 8'h00);
    wr1(ADDR_TAMPER1, 8'hD0);
    batt = 1'b1;
    cyc(6);
    `CHK("batt irq off", 1'b0, irq_oe)
    `CHK("batt rst hiz", 1'b0, rst_oe)
    `CHK("batt ce hiz", 1'b0, ce_oe)
    batt = 1'b0;
    wr1(ADDR_ALARM_CTRL, 8'h20);
    batt = 1'b1;
    cyc(6);
    `CHK("batt irq abe", 1'b1, irq_oe)
    batt = 1'b0;
    cyc(6);
    `CHK("ce driven", 1'b1, ce_oe)
  endtask
  task automatic t_freeze();
    logic ack;
    logic [7:0] d0;
    logic [7:0] d1;
    point(8'h00);
    sel(1'b1, 1'b1);
    m.get_byte(1'b1, d0);
    live = 64'hF0E0D0C0B0A09080;
    m.get_byte(1'b0, d1);
    m.stop_cond();
    `CHK("frozen 00h", 8'h11, d0)
    `CHK("frozen 01h", 8'h22, d1)
    rd1(8'h01, 8'h90);
    point(8'h00);
    for (int i = 0; i < 5; i++) begin
      m.put_byte(8'h11 * (i + 1), ack);
      `CHK("time wr ack", (i < 4), ack)
    end
    `CHK("held in freeze", 0, tw_cnt)
    m.stop_cond();
    for (int i = 0; i < 100 && tw_cnt < 4; i++) cyc(1);
    `CHK("time wr count", 4, tw_cnt)
    `CHK("first time wr", 16'h0011, tw_first)
    `CHK("last time wr", 16'h0344, tw_last)
  endtask
  task automatic t_power();
    logic [7:0] d;
    int i;
    ext_n = 1'b1;
    cyc(4);
    `CHK("ce blocked", 1'b1, ce_n)
    ext_n = 1'b0;
    cyc(4);
    `CHK("ce follows", 1'b0, ce_n)
    pf = 1'b1;
    cyc(6);
    `CHK("rst in fail", 1'b1, rst_oe)
    `CHK("ce in fail", 1'b1, ce_n)
    `CHK("rst pin level", 1'b0, rst_lvl)
    sel(1'b0, 1'b0);
    m.stop_cond();
    pf = 1'b0;
    cyc(REC / 2);
    `CHK("rst recovery", 1'b1, rst_oe)
    `CHK("ce recovery", 1'b1, ce_n)
    for (i = 0; i < REC + 20 && rst_oe !== 1'b0; i++) cyc(1);
    if (i >= REC + 20) begin
      fails++;
      close_out();
    end
    cyc(4);
    `CHK("ce released", 1'b0, ce_n)
    sel(1'b1, 1'b1);
    m.get_byte(1'b0, d);
    m.stop_cond();
    `CHK("pointer reset", 8'h80, d)
  endtask
  initial begin
    cyc(8);
    rst_in = 1'b0;
    cyc(6);
    t_regs();
    t_tamper();
    t_freeze();
    t_power();
    close_out();
  end
endmodule // tb_rtc_serial_access_tamper_flags
`default_nettype wire
